// ---- sfc_pkg.sv ----
`default_nettype none
package sfc_pkg;
	// ---------------------------------------------------------------
	// Opcodes
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_WR_ENABLE = 8'h06;
	localparam logic [7:0] OP_WR_DISABLE = 8'h04;
	localparam logic [7:0] OP_VOL_ENABLE = 8'h50;
	localparam logic [7:0] OP_SR_RD_LO = 8'h05;
	localparam logic [7:0] OP_SR_RD_MID = 8'h35;
	localparam logic [7:0] OP_SR_RD_HI = 8'h15;
	localparam logic [7:0] OP_SR_WR_LO = 8'h01;
	localparam logic [7:0] OP_SR_WR_MID = 8'h31;
	localparam logic [7:0] OP_SR_WR_HI = 8'h11;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST = 8'h0B;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
	localparam logic [7:0] OP_DUAL_IO = 8'hBB;
	localparam logic [7:0] OP_QUAD_IO = 8'hEB;
	localparam logic [7:0] OP_MODE_RST = 8'hFF;
	// ---------------------------------------------------------------
	// Status layout
	// ---------------------------------------------------------------
	localparam int SR_BITS = 24;
	localparam int B_BUSY = 0;
	localparam int B_LATCH = 1;
	localparam int B_PROT_LO = 7;
	localparam int B_PROT_HI = 8;
	localparam int B_QUAD = 9;
	localparam logic [23:0] SR_WR_MASK = 24'hFF7BFC;
	localparam logic [23:0] SR_RESET = 24'h000000;
	// ---------------------------------------------------------------
	// Framing and timing
	// ---------------------------------------------------------------
	localparam int ADDR_BITS = 24;
	localparam logic [4:0] ADDR_LEN = 5'h18;
	localparam logic [4:0] BYTE_LEN = 5'h08;
	localparam logic [4:0] DUMMY_FAST = 5'h08;
	localparam logic [4:0] DUMMY_QUAD = 5'h04;
	localparam logic [3:0] WR_BITS = 4'h8;
	localparam logic [3:0] WR_SAT = 4'h9;
	localparam logic [1:0] MODE_CONT = 2'h2;
	localparam logic [1:0] LN_1 = 2'h0;
	localparam logic [1:0] LN_2 = 2'h1;
	localparam logic [1:0] LN_4 = 2'h2;
	localparam int CLK_PERIOD_NS = 20;
	localparam int SR_WRITE_TIME_NS = 2000;
	localparam logic [7:0] SR_WRITE_CYC =
		8'((SR_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	typedef enum logic [2:0] {
		ST_CMD = 3'b000,
		ST_ADDR = 3'b001,
		ST_MODE = 3'b010,
		ST_DUMMY = 3'b011,
		ST_DATA = 3'b100,
		ST_STAT = 3'b101,
		ST_WBYTE = 3'b110,
		ST_IDLE = 3'b111
	} sfc_state_e;
endpackage
`default_nettype wire

// ---- sfc_front.sv ----
// Functional notes
// RQ1: Opcode 06H in a complete frame sets the write latch bit.
// RQ2: Host sets the write latch before any program, erase or status write.
// RQ3: Opcode 04H clears the write latch bit.
// RQ4: Opcode 04H is ignored while the busy bit is one.
// RQ5: Latch clears on 04H, reset, status write end and program/erase end.
// RQ6: 05H/35H/15H shift out status bytes low/mid/high, repeating, even when busy.
// RQ7: 01H/31H/11H write the next byte to a status byte if latch set.
// RQ8: Status bits 15, 10, 1 and 0 are never written.
// RQ9: A status write is discarded unless select rises after exactly eight bits.
// RQ10: Valid status write starts a timed busy cycle, latch clears at end.
// RQ11: Status writes update block protect and protect mode bits.
// RQ12: Status writes are refused in hardware protected mode.
// RQ13: 50H lets only the next status write change volatile copies.
// RQ14: 03H takes a 24-bit address then streams bytes, address incrementing.
// RQ15: Array reads are rejected while busy without disturbing the cycle.
// RQ16: 0BH takes address and one dummy byte, then streams bytes.
// RQ17: 3BH outputs two bits per clock after address and dummy byte.
// RQ18: 6BH outputs four bits per clock, only with quad enable set.
// RQ19: BBH takes address and mode byte on two lanes, returns two lanes.
// RQ20: Mode bits 5..4 equal 10 make next frame an opcode-less dual read.
// RQ21: A mode reset clears continuous mode and restores opcode decoding.
// RQ22: EBH takes address, mode, four dummy clocks on four lanes, needs quad.
// RQ23: After EBH, mode bits 10 let the next frame omit the opcode.
// RQ24: Unknown opcodes are ignored until select rises, changing nothing.
`timescale 1ns/1ps
`default_nettype none
module sfc_front (
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe,
	input wire logic wp_n,
	input wire logic ext_busy,
	input wire logic ext_done,
	input wire logic [7:0] rd_data,
	output logic [sfc_pkg::ADDR_BITS-1:0] rd_addr,
	output logic [sfc_pkg::SR_BITS-1:0] status
);
	import sfc_pkg::*;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [23:0] shin(input logic [23:0] v, input logic [1:0] ln,
		input logic [3:0] d);
		unique case (ln)
			LN_2: shin = {v[21:0], d[1:0]};
			LN_4: shin = {v[19:0], d};
			default: shin = {v[22:0], d[0]};
		endcase
	endfunction

	function automatic logic [4:0] lastc(input logic [4:0] len, input logic [1:0] ln);
		lastc = (len >> ln) - 5'h01;
	endfunction

	function automatic logic [1:0] dlane(input logic [7:0] op);
		if (op == OP_DUAL_OUT || op == OP_DUAL_IO) begin
			dlane = LN_2;
		end else if (op == OP_QUAD_OUT || op == OP_QUAD_IO) begin
			dlane = LN_4;
		end else begin
			dlane = LN_1;
		end
	endfunction

	// ---------------------------------------------------------------
	// Link side, rising edge of the serial clock
	// ---------------------------------------------------------------
	// The serial clock stops between frames, so frame start is marked by
	// act_reg, which select high clears. Results stay put after the frame
	// so the system side can read them once it has seen select rise.
	logic act_reg;
	sfc_state_e state_reg, state_next, st;
	logic [4:0] cnt_reg, cnt_next, ccnt;
	logic [1:0] ln_reg, ln_next, ln;
	logic [7:0] cmd_reg, cmd_next, mode_reg, mode_next, wbyte_reg, wbyte_next;
	logic [23:0] addr_reg, addr_next, tmp;
	logic [3:0] wcnt_reg, wcnt_next;
	logic cmdok_reg, cmdok_next, cont_reg, cont_next, contq_reg, contq_next;
	logic [23:0] stsy1_reg, stsy2_reg;
	logic rsy1_reg, rsy2_reg, busy_s, qe_s;

	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			act_reg <= 1'b0;
		end else begin
			act_reg <= 1'b1;
		end
	end

	always_comb begin
		busy_s = stsy2_reg[B_BUSY];
		qe_s = stsy2_reg[B_QUAD];
		ccnt = act_reg ? cnt_reg : 5'h00;
		ln = ln_reg;
		st = state_reg;
		if (!act_reg) begin
			st = ST_CMD;
			if (cont_reg) begin
				ln = contq_reg ? LN_4 : LN_2;
				st = (!busy_s && (!contq_reg || qe_s)) ? ST_ADDR : ST_IDLE; // see RQ20 see RQ23
			end
		end
		state_next = st;
		cnt_next = ccnt + 5'h01;
		ln_next = ln;
		cmd_next = cmd_reg;
		cmdok_next = act_reg & cmdok_reg;
		addr_next = addr_reg;
		mode_next = mode_reg;
		wbyte_next = wbyte_reg;
		wcnt_next = act_reg ? wcnt_reg : 4'h0;
		cont_next = cont_reg;
		contq_next = contq_reg;
		tmp = 24'h000000;
		unique case (st)
			ST_CMD: begin
				cmd_next = {cmd_reg[6:0], io_in[0]};
				if (ccnt == lastc(BYTE_LEN, LN_1)) begin
					cnt_next = 5'h00;
					cmdok_next = 1'b1;
					ln_next = LN_1;
					state_next = ST_IDLE; // see RQ24
					case (cmd_next)
						OP_SR_RD_LO, OP_SR_RD_MID, OP_SR_RD_HI: begin
							state_next = ST_STAT; // see RQ6
						end
						OP_SR_WR_LO, OP_SR_WR_MID, OP_SR_WR_HI: begin
							state_next = ST_WBYTE; // see RQ7
						end
						OP_READ, OP_FAST, OP_DUAL_OUT: begin
							if (!busy_s) begin
								state_next = ST_ADDR; // see RQ14 see RQ15 see RQ16 see RQ17
							end
						end
						OP_QUAD_OUT: begin
							if (!busy_s && qe_s) begin
								state_next = ST_ADDR; // see RQ18
							end
						end
						OP_DUAL_IO: begin
							if (!busy_s) begin
								state_next = ST_ADDR; // see RQ19
								ln_next = LN_2;
							end
						end
						OP_QUAD_IO: begin
							if (!busy_s && qe_s) begin
								state_next = ST_ADDR; // see RQ22
								ln_next = LN_4;
							end
						end
						OP_MODE_RST: begin
							cont_next = 1'b0; // see RQ21
						end
						default: begin
						end
					endcase
				end
			end
			ST_ADDR: begin
				addr_next = shin(addr_reg, ln, io_in);
				if (ccnt == lastc(ADDR_LEN, ln)) begin
					cnt_next = 5'h00;
					if (cmd_reg == OP_DUAL_IO || cmd_reg == OP_QUAD_IO) begin
						state_next = ST_MODE;
					end else if (cmd_reg == OP_READ) begin
						state_next = ST_DATA;
					end else begin
						state_next = ST_DUMMY;
					end
				end
			end
			ST_MODE: begin
				tmp = shin({16'h0000, mode_reg}, ln, io_in);
				mode_next = tmp[7:0];
				if (ccnt == lastc(BYTE_LEN, ln)) begin
					cnt_next = 5'h00;
					cont_next = (mode_next[5:4] == MODE_CONT); // see RQ20 see RQ23
					contq_next = (cmd_reg == OP_QUAD_IO);
					state_next = (cmd_reg == OP_QUAD_IO) ? ST_DUMMY : ST_DATA;
				end
			end
			ST_DUMMY: begin
				if (ccnt == ((cmd_reg == OP_QUAD_IO) ? DUMMY_QUAD : DUMMY_FAST) - 5'h01) begin
					cnt_next = 5'h00;
					ln_next = dlane(cmd_reg); // see RQ16 see RQ22
					state_next = ST_DATA;
				end
			end
			ST_DATA: begin
				if (ccnt == lastc(BYTE_LEN, ln)) begin
					cnt_next = 5'h00;
					addr_next = addr_reg + 24'h000001; // see RQ14
				end
			end
			ST_STAT: begin
				if (ccnt == lastc(BYTE_LEN, LN_1)) begin
					cnt_next = 5'h00;
				end
			end
			ST_WBYTE: begin
				wbyte_next = {wbyte_reg[6:0], io_in[0]};
				if (wcnt_next != WR_SAT) begin
					wcnt_next = wcnt_next + 4'h1; // see RQ9
				end
			end
			ST_IDLE: begin
			end
		endcase
		if (rsy2_reg) begin
			cont_next = 1'b0;
		end
	end

	always_ff @(posedge sclk) begin
		rsy1_reg <= rst;
		rsy2_reg <= rsy1_reg;
		stsy1_reg <= status;
		stsy2_reg <= stsy1_reg;
		state_reg <= state_next;
		cnt_reg <= cnt_next;
		ln_reg <= ln_next;
		cmd_reg <= cmd_next;
		cmdok_reg <= cmdok_next;
		addr_reg <= addr_next;
		mode_reg <= mode_next;
		wbyte_reg <= wbyte_next;
		wcnt_reg <= wcnt_next;
		cont_reg <= cont_next;
		contq_reg <= contq_next;
	end

	assign rd_addr = addr_reg;

	// ---------------------------------------------------------------
	// Link side, falling edge: output lanes
	// ---------------------------------------------------------------
	logic [7:0] obyte_reg, obyte_next, ob, sbyte;
	logic [3:0] out_reg, out_next, oe_reg, oe_next;

	always_comb begin
		if (cmd_reg == OP_SR_RD_LO) begin
			sbyte = stsy2_reg[7:0];
		end else if (cmd_reg == OP_SR_RD_MID) begin
			sbyte = stsy2_reg[15:8];
		end else begin
			sbyte = stsy2_reg[23:16];
		end
		ob = obyte_reg;
		if (cnt_reg == 5'h00) begin
			ob = (state_reg == ST_STAT) ? sbyte : rd_data; // see RQ6
		end
		out_next = 4'h0;
		oe_next = 4'h0;
		obyte_next = obyte_reg;
		if (act_reg && (state_reg == ST_DATA || state_reg == ST_STAT)) begin
			unique case (ln_reg)
				LN_2: begin
					out_next = {2'b00, ob[7:6]}; // see RQ17 see RQ19
					oe_next = 4'h3;
					obyte_next = {ob[5:0], 2'b00};
				end
				LN_4: begin
					out_next = ob[7:4]; // see RQ18 see RQ22
					oe_next = 4'hF;
					obyte_next = {ob[3:0], 4'h0};
				end
				default: begin
					out_next = {2'b00, ob[7], 1'b0};
					oe_next = 4'h2;
					obyte_next = {ob[6:0], 1'b0};
				end
			endcase
		end
	end

	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			obyte_reg <= 8'h00;
			out_reg <= 4'h0;
			oe_reg <= 4'h0;
		end else begin
			obyte_reg <= obyte_next;
			out_reg <= out_next;
			oe_reg <= oe_next;
		end
	end

	assign io_out = out_reg;
	assign io_oe = oe_reg;

	// ---------------------------------------------------------------
	// System side: status, latch and write cycle
	// ---------------------------------------------------------------
	// Frame results are read only after select has passed two flops here,
	// by which time the stopped serial clock holds them still.
	logic cs1_reg, cs2_reg, cs3_reg, wp1_reg, wp2_reg;
	logic [23:0] sr_reg, sr_next, nv_reg, nv_next, stat_reg, stat_next, m, wv;
	logic wel_reg, wel_next, arm_reg, arm_next;
	logic [7:0] tmr_reg, tmr_next;
	logic rise, hit, busy, hpm, swr, allowed;

	always_comb begin
		rise = cs2_reg & ~cs3_reg;
		hit = rise & cmdok_reg;
		busy = (tmr_reg != 8'h00) | ext_busy;
		hpm = sr_reg[B_PROT_LO] & ~sr_reg[B_PROT_HI] & ~wp2_reg;
		swr = hit & (cmd_reg == OP_SR_WR_LO || cmd_reg == OP_SR_WR_MID ||
			cmd_reg == OP_SR_WR_HI) & (wcnt_reg == WR_BITS); // see RQ9
		allowed = swr & (wel_reg | arm_reg) & ~hpm & ~busy; // see RQ7 see RQ12
		if (cmd_reg == OP_SR_WR_LO) begin
			m = 24'h0000FF;
		end else if (cmd_reg == OP_SR_WR_MID) begin
			m = 24'h00FF00;
		end else begin
			m = 24'hFF0000;
		end
		m = m & SR_WR_MASK; // see RQ8
		wv = {wbyte_reg, wbyte_reg, wbyte_reg};
		sr_next = sr_reg;
		nv_next = nv_reg;
		tmr_next = busy ? tmr_reg - 8'h01 : 8'h00;
		if (tmr_reg == 8'h00) begin
			tmr_next = 8'h00;
		end
		if (allowed) begin
			sr_next = (sr_reg & ~m) | (wv & m); // see RQ11
			if (!arm_reg) begin
				nv_next = sr_next;
				tmr_next = SR_WRITE_CYC; // see RQ10
			end
		end
		wel_next = wel_reg;
		if ((hit && cmd_reg == OP_WR_DISABLE && !busy) || ext_done ||
			tmr_reg == 8'h01) begin
			wel_next = 1'b0; // see RQ3 see RQ4 see RQ5 see RQ10
		end
		if (hit && cmd_reg == OP_WR_ENABLE) begin
			wel_next = 1'b1; // see RQ1
		end
		arm_next = rise ? (hit && cmd_reg == OP_VOL_ENABLE) : arm_reg; // see RQ13
		stat_next = {sr_reg[23:2], wel_reg, busy};
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cs1_reg <= 1'b1;
			cs2_reg <= 1'b1;
			cs3_reg <= 1'b1;
			wp1_reg <= 1'b1;
			wp2_reg <= 1'b1;
			sr_reg <= SR_RESET;
			nv_reg <= SR_RESET;
			stat_reg <= SR_RESET;
			wel_reg <= 1'b0; // see RQ5
			arm_reg <= 1'b0;
			tmr_reg <= 8'h00;
		end else begin
			cs1_reg <= cs_n;
			cs2_reg <= cs1_reg;
			cs3_reg <= cs2_reg;
			wp1_reg <= wp_n;
			wp2_reg <= wp1_reg;
			sr_reg <= sr_next;
			nv_reg <= nv_next;
			stat_reg <= stat_next;
			wel_reg <= wel_next;
			arm_reg <= arm_next;
			tmr_reg <= tmr_next;
		end
	end

	assign status = stat_reg;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	write_enable_cmd_set_a: assert property (@(posedge clk) disable iff (rst) // see RQ1
		hit && cmd_reg == OP_WR_ENABLE |=> wel_reg ##1 stat_reg[B_LATCH])
		else $error("Write enable frame did not set the latch.");
	write_disable_cmd_clr_a: assert property (@(posedge clk) disable iff (rst) // see RQ3
		hit && cmd_reg == OP_WR_DISABLE && !busy |=> !wel_reg)
		else $error("Write disable frame did not clear the latch.");
	write_disable_cmd_busy_a: assert property (@(posedge clk) disable iff (rst) // see RQ4
		hit && cmd_reg == OP_WR_DISABLE && busy && !ext_done && tmr_reg != 8'h01
		|=> wel_reg == $past(wel_reg))
		else $error("Write disable acted while busy.");
	sr_fixed_a: assert property (@(posedge clk) disable iff (rst) // see RQ8
		!rst |=> $stable(sr_reg & ~SR_WR_MASK))
		else $error("Protected status bit changed.");
	sr_frame_a: assert property (@(posedge clk) disable iff (rst) // see RQ9
		hit && cmd_reg == OP_SR_WR_LO && wcnt_reg != WR_BITS |=> $stable(sr_reg))
		else $error("Badly framed status write took effect.");
	hw_prot_a: assert property (@(posedge clk) disable iff (rst) // see RQ12
		rise && hpm |=> $stable(sr_reg))
		else $error("Status write done in protected mode.");
	nv_cycle_a: assert property (@(posedge clk) disable iff (rst) // see RQ10
		allowed && !arm_reg |=> tmr_reg == SR_WRITE_CYC ##1 stat_reg[B_BUSY])
		else $error("Status write cycle did not start.");
	wel_end_a: assert property (@(posedge clk) disable iff (rst) // see RQ5
		tmr_reg == 8'h01 && !(hit && cmd_reg == OP_WR_ENABLE) |=> !wel_reg)
		else $error("Latch not cleared at end of write cycle.");
	vol_write_a: assert property (@(posedge clk) disable iff (rst) // see RQ13
		allowed && arm_reg |=> tmr_reg == 8'h00 && $stable(nv_reg) && !arm_reg)
		else $error("Volatile write touched the stored copy.");
	quad_gate_a: assert property (@(posedge sclk) disable iff (cs_n) // see RQ18
		act_reg && state_reg == ST_CMD && cnt_reg == 5'h07 && !qe_s &&
		{cmd_reg[6:0], io_in[0]} == OP_QUAD_OUT |=> state_reg == ST_IDLE)
		else $error("Quad read accepted without quad enable.");
	read_busy_a: assert property (@(posedge sclk) disable iff (cs_n) // see RQ15
		act_reg && state_reg == ST_CMD && cnt_reg == 5'h07 && busy_s &&
		{cmd_reg[6:0], io_in[0]} == OP_READ |=> state_reg == ST_IDLE)
		else $error("Read accepted while busy.");
endmodule
`default_nettype wire

// ---- sfc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfc_host (
	output logic cs_n,
	output logic sclk,
	output logic [3:0] drv,
	input wire logic [3:0] io
);
	logic [3:0] last;

	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		drv = 4'h0;
		last = 4'h0;
	end

	task automatic sel();
		cs_n = 1'b0;
		#40;
	endtask

	// Select rises right after the last bit, so a whole status byte is never padded.
	task automatic desel();
		#40;
		cs_n = 1'b1;
		drv = ~last;
		#200;
	endtask

	// A released lane shows the inverse of its last value, so a stale bit never passes.
	// Shifts n clocks on w lanes, MSB first, at a 64 ns link period; sclk idles low.
	task automatic shift(input int n, input int w, input logic hold, input logic [63:0] tx,
		output logic [63:0] rx);
		rx = '0;
		for (int i = n - 1; i >= 0; i--) begin
			if (hold) begin
				last = 4'((tx >> (i * w)) & ((64'h1 << w) - 1));
				drv = last;
			end else
				drv = ~last;
			#32;
			sclk = 1'b1;
			rx = (rx << w) | ((w == 1) ? 64'(io[1]) : 64'(io & 4'((1 << w) - 1)));
			#32;
			sclk = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sfc_pkg::*;
	logic clk, rst, wp_n, ext_busy, ext_done, cs_n, sclk;
	logic [3:0] drv, io_in, io_out, io_oe;
	logic [7:0] rd_data;
	logic [23:0] rd_addr, status;
	logic [63:0] rx;
	int failures, checked;
	logic [7:0] op_t[6] = '{OP_READ, OP_FAST, OP_DUAL_OUT, OP_QUAD_OUT, OP_DUAL_IO, OP_QUAD_IO};
	int aw_t[6] = '{1, 1, 1, 1, 2, 4};
	int mc_t[6] = '{0, 0, 0, 0, 4, 2};
	int dc_t[6] = '{0, 8, 8, 8, 0, 4};
	int dw_t[6] = '{1, 1, 2, 4, 2, 4};
	logic [7:0] wr_t[3] = '{OP_SR_WR_LO, OP_SR_WR_MID, OP_SR_WR_HI};
	logic [7:0] rs_t[3] = '{OP_SR_RD_LO, OP_SR_RD_MID, OP_SR_RD_HI};
	logic [7:0] ex_t[3] = '{8'hFC, 8'h7B, 8'hFF};

	function automatic logic [7:0] mem(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
	endfunction

	assign io_in = (io_oe & io_out) | (~io_oe & drv);
	assign rd_data = mem(rd_addr);

	sfc_front DUT (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe), .wp_n(wp_n), .ext_busy(ext_busy),
		.ext_done(ext_done), .rd_data(rd_data), .rd_addr(rd_addr), .status(status));
	sfc_host HOST (.cs_n(cs_n), .sclk(sclk), .drv(drv), .io(io_in));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ----
	// Access tasks
	// ----
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		if (failures == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic cmd(input logic [7:0] op, input int n, input logic [63:0] tx);
		HOST.sel();
		HOST.shift(8, 1, 1'b1, 64'(op), rx);
		if (n > 0)
			HOST.shift(n, 1, 1'b1, tx, rx);
		HOST.desel();
		cyc(8);
	endtask

	task automatic sread(input logic [7:0] op);
		HOST.sel();
		HOST.shift(8, 1, 1'b1, 64'(op), rx);
		HOST.shift(16, 1, 1'b0, 64'h0, rx);
		HOST.desel();
	endtask

	// Two data bytes are read so that the address step across a byte carry is seen.
	task automatic rdx(input logic op_on, input logic [7:0] op, input int aw, input int mc,
		input logic [7:0] mode, input int dc, input int dw, input logic [23:0] a,
		input logic ok);
		HOST.sel();
		if (op_on)
			HOST.shift(8, 1, 1'b1, 64'(op), rx);
		HOST.shift(24 / aw, aw, 1'b1, 64'(a), rx);
		if (mc > 0)
			HOST.shift(mc, aw, 1'b1, 64'(mode), rx);
		if (dc > 0)
			HOST.shift(dc, aw, 1'b0, 64'h0, rx);
		HOST.shift(16 / dw, dw, 1'b0, 64'h0, rx);
		// The enables move on the falling edge that ends the shift, so settle first.
		#1;
		if (ok)
			check(rx[15:0], {mem(a), mem(24'(a + 1))});
		else
			check(io_oe, 4'h0);
		HOST.desel();
	endtask

	task automatic wait_idle();
		int k;
		k = 0;
		while (status[B_BUSY] !== 1'b0 && k < 300) begin
			cyc(1);
			k++;
		end
		if (k == 300) begin
			failures++;
			give_verdict();
		end
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		failures = 0;
		checked = 0;
		rst = 1'b1;
		wp_n = 1'b1;
		ext_busy = 1'b0;
		ext_done = 1'b0;
		repeat (12) @(posedge clk);
		#2;
		rst = 1'b0;
		cyc(4);
		check(status, 24'h0);
		rdx(1'b1, OP_QUAD_OUT, 1, 0, 8'h00, 8, 4, 24'h000010, 1'b0);
		cmd(OP_WR_ENABLE, 0, 64'h0);
		check(status[B_LATCH], 1'b1);
		cmd(OP_WR_DISABLE, 0, 64'h0);
		check(status[B_LATCH], 1'b0);
		cmd(OP_SR_WR_LO, 8, 64'hFF);
		check(status, 24'h0);
		for (int i = 0; i < 3; i++) begin
			if (i == 1) begin
				wp_n = 1'b0;
				cmd(OP_WR_ENABLE, 0, 64'h0);
				cmd(OP_SR_WR_MID, 8, 64'hFF);
				check(status[15:8], 8'h00);
				wp_n = 1'b1;
			end
			cmd(OP_WR_ENABLE, 0, 64'h0);
			cmd(wr_t[i], 8, 64'hFF);
			check(status[B_BUSY], 1'b1);
			wait_idle();
			check(status[B_LATCH], 1'b0);
			sread(rs_t[i]);
			check(rx[15:0], {2{ex_t[i]}});
		end
		cmd(OP_WR_ENABLE, 0, 64'h0);
		cmd(OP_SR_WR_LO, 9, 64'h0);
		check(status, 24'hFF7BFE);
		cmd(OP_VOL_ENABLE, 0, 64'h0);
		cmd(OP_SR_WR_LO, 8, 64'h0);
		check(status, 24'hFF7B02);
		cmd(OP_WR_DISABLE, 0, 64'h0);
		for (int i = 0; i < 6; i++)
			rdx(1'b1, op_t[i], aw_t[i], mc_t[i], 8'h00, dc_t[i], dw_t[i], 24'h1234FF, 1'b1);
		// The opcode-less frame carries a mode byte that ends continuous decoding again.
		for (int i = 4; i < 6; i++) begin
			rdx(1'b1, op_t[i], aw_t[i], mc_t[i], 8'h20, dc_t[i], dw_t[i], 24'h00AB0F, 1'b1);
			rdx(1'b0, op_t[i], aw_t[i], mc_t[i], 8'h00, dc_t[i], dw_t[i], 24'h3C00FF, 1'b1);
			rdx(1'b1, OP_READ, 1, 0, 8'h00, 0, 1, 24'h000100, 1'b1);
		end
		rdx(1'b1, OP_QUAD_IO, 4, 2, 8'h20, 4, 4, 24'h0F0F0F, 1'b1);
		HOST.sel();
		HOST.shift(8, 4, 1'b1, 64'hFFFFFFFF, rx);
		HOST.desel();
		rdx(1'b1, OP_READ, 1, 0, 8'h00, 0, 1, 24'h7FFFFF, 1'b1);
		HOST.sel();
		HOST.shift(16, 1, 1'b1, 64'hA5A5, rx);
		#1;
		check(io_oe, 4'h0);
		HOST.desel();
		cyc(8);
		check(status, 24'hFF7B00);
		cmd(OP_WR_ENABLE, 0, 64'h0);
		ext_busy = 1'b1;
		cyc(4);
		cmd(OP_WR_DISABLE, 0, 64'h0);
		check(status[B_LATCH], 1'b1);
		sread(OP_SR_RD_LO);
		check(rx[15:0], 16'h0303);
		rdx(1'b1, OP_READ, 1, 0, 8'h00, 0, 1, 24'h000020, 1'b0);
		ext_busy = 1'b0;
		cyc(1);
		ext_done = 1'b1;
		cyc(1);
		ext_done = 1'b0;
		cyc(4);
		check(status[1:0], 2'b00);
		give_verdict();
	end
endmodule
`default_nettype wire
